// ### hw/cci_pkg.sv
// Shared constants for the conductivity command interpreter.
package cci_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int PROC_SHORT_MS = 300;
  localparam int PROC_READ_MS = 1000;
  localparam int PROC_CAL_MS = 1300;
  localparam int BLINK_MS = 150;
  localparam int PROC_SHORT_CYC = PROC_SHORT_MS * CYC_PER_MS;
  localparam int PROC_READ_CYC = PROC_READ_MS * CYC_PER_MS;
  localparam int PROC_CAL_CYC = PROC_CAL_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int CNT_W = 27;
  localparam int REPLY_BYTES = 32;
  localparam int REPLY_AW = 5;
  localparam int CMD_BYTES = 16;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_READ0 = 5'h10;
  localparam int CTRL_ADDR_LSB = 0;
  localparam logic [6:0] CTRL_ADDR_RST = 7'h64;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_LED_BIT = 8;
  localparam int ST_CAL_LSB = 9;
  localparam int ST_BUSY_BIT = 11;
  localparam int ST_LOWP_BIT = 12;
  localparam logic [7:0] RSP_OK = 8'h01;
  localparam logic [7:0] RSP_FAIL = 8'h02;
  localparam logic [7:0] RSP_PEND = 8'hfe;
  localparam logic [7:0] RSP_NONE = 8'hff;
  localparam logic [63:0] K_RST = {"1.0", 40'h0};
  localparam logic [63:0] T_RST = {"25", 48'h0};
  localparam logic [7:0] WHY_POWER = "P";
  localparam logic [7:0] WHY_SOFT = "S";
  typedef enum logic [1:0] {DLY_SHORT, DLY_READ, DLY_CAL} cci_dly_e;
endpackage : cci_pkg

// ### hw/cci_reply_mem.sv
// Reply byte store with registered read data.
`timescale 1ns/100ps
`default_nettype none
module cci_reply_mem
  import cci_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [REPLY_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [REPLY_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [REPLY_BYTES];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : cci_reply_mem
`default_nettype wire

// ### hw/cci_top.sv
// I2C-slave command interpreter with Avalon-MM control and indicator drive.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module cci_top
  import cci_pkg::*;
#(
  parameter int PROC_SHORT_CYCLES = PROC_SHORT_CYC,
  parameter int PROC_READ_CYCLES = PROC_READ_CYC,
  parameter int PROC_CAL_CYCLES = PROC_CAL_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic led_red,
  output logic led_green,
  output logic led_blue
);
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACKA, I_WR, I_ACKW, I_RD, I_ACKR, I_WAITP} cci_i2c_e;
  typedef enum logic [1:0] {EX_IDLE, EX_WAIT, EX_FILL} cci_ex_e;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= "a" && c <= "z") ? c - 8'h20 : c;
  endfunction : upcase

  // Accepts a plain decimal between 0.1 and 10 inclusive.
  function automatic logic k_ok(input logic [63:0] v);
    logic [7:0] c;
    int ip;
    logic dot, bad, any, fnz, ffirst, fpos;
    ip = 0;
    dot = 1'h0;
    bad = 1'h0;
    any = 1'h0;
    fnz = 1'h0;
    ffirst = 1'h0;
    fpos = 1'h1;
    for (int i = 0; i < 8; i++) begin
      c = v[63-8*i -: 8];
      if (c == "." && !dot) begin
        dot = 1'h1;
      end else if (c >= "0" && c <= "9") begin
        any = 1'h1;
        if (!dot) begin
          ip = (ip > 99) ? ip : ip * 10 + int'(c) - 48;
        end else begin
          if (fpos && c != "0") ffirst = 1'h1;
          if (c != "0") fnz = 1'h1;
          fpos = 1'h0;
        end
      end else if (c != 8'h00) begin
        bad = 1'h1;
      end
    end
    return !bad && any && ((ip >= 1 && ip <= 9) || (ip == 10 && !fnz) || (ip == 0 && ffirst));
  endfunction : k_ok

  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'h0;
      rst_n_reg <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
    end
  end
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_ev = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_ev = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  cci_i2c_e i2c_st;
  cci_ex_e ex_st;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg, tx_byte, status_reg, mem_rdata, rst_why_reg;
  logic rw_reg, first_reg, nul_seen_reg, wtxn_reg, rtxn_reg, cmd_go_reg, rd_done_reg;
  logic [5:0] rd_idx_reg;
  logic [4:0] wr_cnt_reg, fill_idx_reg;
  logic [7:0] cmd_buf [CMD_BYTES];
  logic [127:0] cw, reading_reg, frozen_reg;
  logic [6:0] addr_reg;
  logic ld, wr_store, addr_hit;
  assign ld = scl_fall && ((i2c_st == I_ACKA && rw_reg) || i2c_st == I_ACKR);
  assign wr_store = scl_fall && i2c_st == I_WR && bit_cnt_reg == 4'h8;
  assign addr_hit = scl_fall && i2c_st == I_ADDR && bit_cnt_reg == 4'h8 && sh_reg[7:1] == addr_reg;
  // The link has no clock output at all: the slave answers only through data and status.
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      i2c_st <= I_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      rw_reg <= 1'h0;
      sda_oe <= 1'h0;
      sda_out <= 1'h0;
    end else if (start_ev) begin
      i2c_st <= I_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe <= 1'h0;
    end else if (stop_ev) begin
      i2c_st <= I_IDLE;
      sda_oe <= 1'h0;
    end else begin
      unique case (i2c_st)
        I_IDLE, I_WAITP: ;
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (i2c_st == I_WR || addr_hit) begin
              if (i2c_st == I_ADDR) rw_reg <= sh_reg[0];
              sda_oe <= 1'h1;
              i2c_st <= (i2c_st == I_WR) ? I_ACKW : I_ACKA;
            end else begin
              i2c_st <= I_WAITP;
            end
          end
        end
        I_ACKA, I_ACKR: begin
          if (i2c_st == I_ACKR && scl_rise && sda_s2_reg) begin
            i2c_st <= I_WAITP;
          end else if (ld) begin
            sh_reg <= tx_byte;
            sda_oe <= !tx_byte[7];
            bit_cnt_reg <= 4'h0;
            i2c_st <= I_RD;
          end else if (scl_fall) begin
            sda_oe <= 1'h0;
            bit_cnt_reg <= 4'h0;
            i2c_st <= I_WR;
          end
        end
        I_ACKW: begin
          if (scl_fall) begin
            sda_oe <= 1'h0;
            bit_cnt_reg <= 4'h0;
            i2c_st <= I_WR;
          end
        end
        I_RD: begin
          if (scl_fall && bit_cnt_reg == 4'h7) begin
            sda_oe <= 1'h0;
            i2c_st <= I_ACKR;
          end else if (scl_fall) begin
            sh_reg <= {sh_reg[6:0], 1'h0};
            sda_oe <= !sh_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  always_comb begin
    tx_byte = 8'h00;
    if (first_reg) begin
      tx_byte = status_reg;
    end else if (status_reg == RSP_OK && !nul_seen_reg && rd_idx_reg != 6'd32) begin
      tx_byte = mem_rdata;
    end
  end

  // Read pointer, command capture and transaction end pulses.
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      first_reg <= 1'h0;
      nul_seen_reg <= 1'h0;
      rd_idx_reg <= 6'h00;
      wr_cnt_reg <= 5'h00;
      wtxn_reg <= 1'h0;
      rtxn_reg <= 1'h0;
      cmd_go_reg <= 1'h0;
      rd_done_reg <= 1'h0;
      for (int i = 0; i < CMD_BYTES; i++) cmd_buf[i] <= 8'h00;
    end else begin
      cmd_go_reg <= (start_ev || stop_ev) && wtxn_reg && wr_cnt_reg != 5'h00;
      rd_done_reg <= (start_ev || stop_ev) && rtxn_reg;
      if (start_ev || stop_ev) begin
        wtxn_reg <= 1'h0;
        rtxn_reg <= 1'h0;
      end
      if (addr_hit) begin
        first_reg <= sh_reg[0];
        wtxn_reg <= !sh_reg[0];
        rd_idx_reg <= 6'h00;
        nul_seen_reg <= 1'h0;
        if (!sh_reg[0]) begin
          wr_cnt_reg <= 5'h00;
          for (int i = 0; i < CMD_BYTES; i++) cmd_buf[i] <= 8'h00;
        end
      end
      if (ld) begin
        first_reg <= 1'h0;
        rtxn_reg <= 1'h1;
        if (!first_reg) begin
          if (rd_idx_reg != 6'd32) rd_idx_reg <= rd_idx_reg + 6'h01;
          if (tx_byte == 8'h00) nul_seen_reg <= 1'h1;
        end
      end
      if (wr_store && wr_cnt_reg != 5'd16) begin
        cmd_buf[wr_cnt_reg[3:0]] <= upcase(sh_reg);
        wr_cnt_reg <= wr_cnt_reg + 5'h01;
      end
    end
  end

  for (genvar g = 0; g < CMD_BYTES; g++) begin : g_cw
    assign cw[127-8*g -: 8] = cmd_buf[g];
  end

  cci_dly_e dly_sel;
  always_comb begin
    dly_sel = DLY_SHORT;
    if (wr_cnt_reg == 5'h01 && cw[127 -: 8] == "R") begin
      dly_sel = DLY_READ;
    end else if (cw[127 -: 32] == "CAL," && (cw[95 -: 8] == "D" || cw[95 -: 8] == "O" ||
                 cw[95 -: 8] == "L" || cw[95 -: 8] == "H")) begin
      dly_sel = DLY_CAL;
    end
  end

  // Command decode and stored settings.
  logic [255:0] txt_reg;
  logic ok_reg, cyan_reg, led_en_reg, low_pend_reg;
  logic [63:0] k_str_reg, t_str_reg;
  logic [1:0] cal_reg;
  logic [4:0] len;
  assign len = wr_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      txt_reg <= '0;
      ok_reg <= 1'h0;
      cyan_reg <= 1'h0;
      led_en_reg <= 1'h1;
      k_str_reg <= K_RST;
      t_str_reg <= T_RST;
      cal_reg <= 2'h0;
      low_pend_reg <= 1'h0;
      frozen_reg <= '0;
      rst_why_reg <= WHY_POWER;
    end else if (cmd_go_reg) begin
      txt_reg <= '0;
      ok_reg <= 1'h1;
      cyan_reg <= dly_sel != DLY_SHORT;
      if (len == 5'h01 && cw[127 -: 8] == "I") begin
        txt_reg <= {"?I,EC,1.0", 184'h0};
      end else if (len == 5'h01 && cw[127 -: 8] == "R") begin
        txt_reg <= {low_pend_reg ? frozen_reg : reading_reg, 128'h0};
      end else if (len == 5'h01 && cw[127 -: 8] == "X") begin
        led_en_reg <= 1'h1;
        k_str_reg <= K_RST;
        t_str_reg <= T_RST;
        cal_reg <= 2'h0;
        low_pend_reg <= 1'h0;
        rst_why_reg <= WHY_SOFT;
      end else if (cw[127 -: 16] == "L," && len == 5'h03) begin
        if (cw[111 -: 8] == "1") led_en_reg <= 1'h1;
        else if (cw[111 -: 8] == "0") led_en_reg <= 1'h0;
        else if (cw[111 -: 8] == "?") txt_reg <= {"?L,", 7'h18, led_en_reg, 224'h0};
        else ok_reg <= 1'h0;
      end else if (cw[127 -: 16] == "K,") begin
        if (len == 5'h03 && cw[111 -: 8] == "?") txt_reg <= {"?K,", k_str_reg, 168'h0};
        else if (len <= 5'd10 && k_ok(cw[111 -: 64])) k_str_reg <= cw[111 -: 64];
        else ok_reg <= 1'h0;
      end else if (cw[127 -: 16] == "T," && len > 5'h02) begin
        if (len == 5'h03 && cw[111 -: 8] == "?") txt_reg <= {"?T,", t_str_reg, 168'h0};
        else if (len <= 5'd10) t_str_reg <= cw[111 -: 64];
        else ok_reg <= 1'h0;
      end else if (cw[127 -: 32] == "CAL,") begin
        if (len == 5'd9 && cw[95 -: 40] == "CLEAR") begin
          cal_reg <= 2'h0;
          low_pend_reg <= 1'h0;
        end else if (len == 5'd7 && cw[95 -: 24] == "DRY") begin
          cal_reg <= cal_reg;
        end else if (len > 5'd8 && cw[95 -: 32] == "ONE,") begin
          cal_reg <= 2'h1;
          low_pend_reg <= 1'h0;
        end else if (len > 5'd8 && cw[95 -: 32] == "LOW,") begin
          low_pend_reg <= 1'h1;
          frozen_reg <= reading_reg;
        end else if (len > 5'd9 && cw[95 -: 40] == "HIGH,") begin
          cal_reg <= 2'h2;
          low_pend_reg <= 1'h0;
        end else if (len == 5'd5 && cw[95 -: 8] == "?") begin
          txt_reg <= {"?CAL,", 6'h0c, cal_reg, 208'h0};
        end else begin
          ok_reg <= 1'h0;
        end
      end else if (cw[127 -: 16] == "O," || cw[127 -: 56] == "SERIAL,") begin
        ok_reg <= 1'h1;
      end else if (len == 5'd5 && cw[127 -: 40] == "SLEEP") begin
        ok_reg <= 1'h1;
      end else if (len == 5'd6 && cw[127 -: 48] == "STATUS") begin
        txt_reg <= {"?STATUS,", rst_why_reg, 184'h0};
      end else begin
        ok_reg <= 1'h0;
      end
    end
  end

  // Processing delay, reply fill and status code.
  logic [CNT_W-1:0] cnt_reg;
  logic [255:0] txt_sh;
  logic fill_last;
  assign txt_sh = txt_reg << {fill_idx_reg, 3'h0};
  assign fill_last = ex_st == EX_FILL && fill_idx_reg == 5'h1f;
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ex_st <= EX_IDLE;
      cnt_reg <= '0;
      fill_idx_reg <= 5'h00;
      status_reg <= RSP_NONE;
    end else if (cmd_go_reg) begin
      ex_st <= EX_WAIT;
      status_reg <= RSP_PEND;
      unique case (dly_sel)
        DLY_SHORT: cnt_reg <= CNT_W'(PROC_SHORT_CYCLES - 1);
        DLY_READ: cnt_reg <= CNT_W'(PROC_READ_CYCLES - 1);
        DLY_CAL: cnt_reg <= CNT_W'(PROC_CAL_CYCLES - 1);
        default: cnt_reg <= CNT_W'(PROC_SHORT_CYCLES - 1);
      endcase
    end else begin
      unique case (ex_st)
        EX_IDLE: begin
          if (rd_done_reg && status_reg != RSP_PEND) status_reg <= RSP_NONE;
        end
        EX_WAIT: begin
          if (cnt_reg == '0) begin
            ex_st <= EX_FILL;
            fill_idx_reg <= 5'h00;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        EX_FILL: begin
          fill_idx_reg <= fill_idx_reg + 5'h01;
          if (fill_last) begin
            ex_st <= EX_IDLE;
            status_reg <= ok_reg ? RSP_OK : RSP_FAIL;
          end
        end
      endcase
    end
  end

  cci_reply_mem u_mem (
    .clk(core_clk),
    .wr_en(ex_st == EX_FILL),
    .wr_addr(fill_idx_reg),
    .wr_data(txt_sh[255:248]),
    .rd_addr(rd_idx_reg[4:0]),
    .rd_data(mem_rdata)
  );

  // Blink phases count down on a slow tick; red takes precedence over a blue blink.
  logic [CNT_W-1:0] blk_tmr_reg;
  logic [2:0] blk_ph_reg;
  logic blk_red_reg;
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      blk_tmr_reg <= '0;
      blk_ph_reg <= 3'h0;
      blk_red_reg <= 1'h0;
    end else if (fill_last && !ok_reg) begin
      blk_red_reg <= 1'h1;
      blk_ph_reg <= 3'h4;
      blk_tmr_reg <= CNT_W'(BLINK_CYCLES - 1);
    end else if (rd_done_reg && !(blk_red_reg && blk_ph_reg != 3'h0)) begin
      blk_red_reg <= 1'h0;
      blk_ph_reg <= 3'h2;
      blk_tmr_reg <= CNT_W'(BLINK_CYCLES - 1);
    end else if (blk_ph_reg != 3'h0) begin
      if (blk_tmr_reg == '0) begin
        blk_ph_reg <= blk_ph_reg - 3'h1;
        blk_tmr_reg <= CNT_W'(BLINK_CYCLES - 1);
      end else begin
        blk_tmr_reg <= blk_tmr_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {led_red, led_green, led_blue} <= 3'h0;
    end else if (!led_en_reg) begin
      {led_red, led_green, led_blue} <= 3'h0;
    end else if (blk_ph_reg != 3'h0) begin
      led_red <= blk_red_reg && !blk_ph_reg[0];
      led_green <= 1'h0;
      led_blue <= !blk_red_reg && blk_ph_reg[0];
    end else if (ex_st == EX_WAIT && cyan_reg) begin
      {led_red, led_green, led_blue} <= 3'h3;
    end else begin
      {led_red, led_green, led_blue} <= 3'h1;
    end
  end

  // Every access is answered on the second cycle of the request.
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      avs_waitrequest <= 1'h1;
      avs_readdata <= 32'h0;
      addr_reg <= CTRL_ADDR_RST;
      reading_reg <= '0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= 32'h0;
        if (avs_address == REG_CTRL) begin
          avs_readdata[CTRL_ADDR_LSB +: 7] <= addr_reg;
        end else if (avs_address == REG_STATUS) begin
          avs_readdata[ST_CODE_LSB +: 8] <= status_reg;
          avs_readdata[ST_LED_BIT] <= led_en_reg;
          avs_readdata[ST_CAL_LSB +: 2] <= cal_reg;
          avs_readdata[ST_BUSY_BIT] <= ex_st != EX_IDLE;
          avs_readdata[ST_LOWP_BIT] <= low_pend_reg;
        end else if (avs_address[4]) begin
          avs_readdata <= reading_reg[127 - 32*avs_address[3:2] -: 32];
        end
      end
      if (avs_write && !avs_waitrequest) begin
        if (avs_address == REG_CTRL) addr_reg <= avs_writedata[CTRL_ADDR_LSB +: 7];
        else if (avs_address[4]) reading_reg[127 - 32*avs_address[3:2] -: 32] <= avs_writedata;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_reg);

  chk_first_status: assert property (ld && first_reg |=> sh_reg == $past(status_reg))
    else $error("first read byte is not the status code");
  chk_none_code: assert property (ex_st == EX_IDLE && status_reg != RSP_OK && status_reg != RSP_FAIL
    |-> status_reg == RSP_NONE)
    else $error("idle without reply but status is not 255");
  chk_pend_code: assert property (ex_st != EX_IDLE |-> status_reg == RSP_PEND)
    else $error("busy but status is not 254");
  chk_fail_code: assert property (fill_last && !ok_reg |=> status_reg == RSP_FAIL)
    else $error("failed command did not report 2");
  chk_ok_code: assert property (fill_last && ok_reg |=> status_reg == RSP_OK)
    else $error("successful command did not report 1");
  chk_nul_tail: assert property (ld && !first_reg && (nul_seen_reg || rd_idx_reg == 6'd32)
    |=> sh_reg == 8'h00)
    else $error("byte after payload end is not NUL");
  chk_sda_drive: assert property (sda_oe |-> i2c_st inside {I_ACKA, I_ACKW, I_RD})
    else $error("data line driven outside ack or read slot");
  chk_cmd_pend: assert property (cmd_go_reg |=> status_reg == RSP_PEND && ex_st == EX_WAIT ##1
    ex_st == EX_WAIT)
    else $error("new command did not drop the held reply");
  chk_cyan_led: assert property (ex_st == EX_WAIT && cyan_reg && led_en_reg && blk_ph_reg == 3'h0
    |=> led_green && led_blue && !led_red)
    else $error("indicator not cyan while measuring");
  chk_led_off: assert property (!led_en_reg |=> !led_red && !led_green && !led_blue)
    else $error("indicator lit while disabled");
  chk_red_blink: assert property (fill_last && !ok_reg |=> blk_red_reg && blk_ph_reg == 3'h4)
    else $error("failure did not start the red double blink");

  cov_cmd: cover property (cmd_go_reg);
  cov_cyan_ok: cover property (fill_last && ok_reg && cyan_reg);
  cov_reply_read: cover property (rd_done_reg && status_reg == RSP_OK);
  cov_fail: cover property (fill_last && !ok_reg);
endmodule : cci_top
`default_nettype wire

// ### verification/cci_i2c_master.sv
// Behavioural I2C master for the bench.
`timescale 1ns/100ps
`default_nettype none
module cci_i2c_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // The 7 ns offset keeps link edges away from core_clk edges.
  task automatic start;
    #7;
    sda_pull = 1'b1;
    #40;
    scl = 1'b0;
  endtask : start
  task automatic stop;
    #20;
    sda_pull = 1'b1;
    #60;
    scl = 1'b1;
    #40;
    sda_pull = 1'b0;
    #80;
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    #20;
    sda_pull = ~b;
    #60;
    scl = 1'b1;
    #40;
    r = sda;
    #40;
    scl = 1'b0;
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(last, ack);
  endtask : xfer
endmodule : cci_i2c_master
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the command interpreter.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cci_pkg::*;
;
  localparam int SHORT = 200;
  localparam int RD = 400;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sda_oe, led_red, led_green, led_blue, scl, moe;
  wire sda = ~(sda_oe | moe);
  int n_mismatch = 0;
  int n_tests = 0;
  always #10 core_clk = ~core_clk;
  cci_top #(.PROC_SHORT_CYCLES(SHORT), .PROC_READ_CYCLES(RD), .PROC_CAL_CYCLES(500), .BLINK_CYCLES(50)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .led_red(led_red), .led_green(led_green), .led_blue(led_blue));
  cci_i2c_master m (.scl(scl), .sda_pull(moe), .sda(sda));
  task automatic end_of_test;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : av
  task automatic i2c_wr(input string s);
    logic [7:0] r;
    logic a;
    m.start();
    m.xfer({CTRL_ADDR_RST, 1'b0}, 1'b1, r, a);
    chk(a, 0);
    for (int i = 0; i < s.len(); i++) begin
      m.xfer(s[i], 1'b1, r, a);
      chk(a, 0);
    end
    m.stop();
  endtask : i2c_wr
  task automatic i2c_rd(input logic [7:0] st, input string s, input int n);
    logic [7:0] r;
    logic a;
    m.start();
    m.xfer({CTRL_ADDR_RST, 1'b1}, 1'b1, r, a);
    chk(a, 0);
    m.xfer(8'hff, n == 0, r, a);
    chk(r, st);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, i == n - 1, r, a);
      chk(r, i < s.len() ? s[i] : 8'h00);
    end
    m.stop();
  endtask : i2c_rd
  task automatic t_idle;
    chk({led_red, led_green, led_blue}, 3'b001);
    i2c_rd(RSP_NONE, "", 3);
  endtask : t_idle
  task automatic t_short;
    string c[8] = '{"i", "L,?", "K,?", "T,?", "CAL,?", "CAL,CLEAR", "O,EC,1", "STATUS"};
    string e[8] = '{"?I,EC,1.0", "?L,1", "?K,1.0", "?T,25", "?CAL,0", "", "", "?STATUS,P"};
    i2c_wr("I");
    cyc(SHORT + 40);
    for (int i = 0; i < 8; i++) begin
      i2c_wr(c[i]);
      i2c_rd(RSP_PEND, "", 1);
      cyc(SHORT + 40);
      i2c_rd(RSP_OK, e[i], 12);
    end
  endtask : t_short
  task automatic t_bad;
    logic seen;
    seen = 1'b0;
    i2c_wr("Q");
    repeat (SHORT + 140) begin
      @(posedge core_clk);
      seen |= led_red;
    end
    chk(seen, 1);
    i2c_rd(RSP_FAIL, "", 2);
  endtask : t_bad
  task automatic t_read;
    logic [31:0] q;
    av(1'b1, REG_READ0, "12.3", q);
    i2c_wr("R");
    cyc(200);
    chk({led_red, led_green, led_blue}, 3'b011);
    cyc(RD);
    i2c_rd(RSP_OK, "12.3", 6);
    cyc(10);
    chk({led_red, led_green, led_blue}, 3'b000);
    cyc(140);
    chk({led_red, led_green, led_blue}, 3'b001);
  endtask : t_read
  task automatic cmd(input string c, input logic [7:0] st, input string e, input int w);
    i2c_wr(c);
    cyc(w);
    i2c_rd(st, e, 12);
  endtask : cmd
  task automatic t_cal;
    logic [31:0] q;
    i2c_wr("CAL,DRY");
    cyc(200);
    chk({led_red, led_green, led_blue}, 3'b011);
    cyc(340);
    i2c_rd(RSP_OK, "", 2);
    cmd("CAL,LOW,1000", RSP_OK, "", 540);
    av(1'b1, REG_READ0, "45.6", q);
    cmd("R", RSP_OK, "12.3", RD + 40);
    cmd("CAL,HIGH,5000", RSP_OK, "", 540);
    cmd("R", RSP_OK, "45.6", RD + 40);
    cmd("CAL,?", RSP_OK, "?CAL,2", SHORT + 40);
    cmd("CAL,ONE,700", RSP_OK, "", 540);
    cmd("CAL,?", RSP_OK, "?CAL,1", SHORT + 40);
  endtask : t_cal
  task automatic t_set;
    cmd("L,0", RSP_OK, "", SHORT + 40);
    chk({led_red, led_green, led_blue}, 3'b000);
    cmd("L,?", RSP_OK, "?L,0", SHORT + 40);
    cmd("L,1", RSP_OK, "", SHORT + 40);
    cmd("K,0.66", RSP_OK, "", SHORT + 40);
    cmd("K,?", RSP_OK, "?K,0.66", SHORT + 40);
    cmd("K,11", RSP_FAIL, "", SHORT + 40);
    cmd("T,19.5", RSP_OK, "", SHORT + 40);
    cmd("T,?", RSP_OK, "?T,19.5", SHORT + 40);
    cmd("SLEEP", RSP_OK, "", SHORT + 40);
    cmd("SERIAL,9600", RSP_OK, "", SHORT + 40);
    cmd("X", RSP_OK, "", SHORT + 40);
    cmd("STATUS", RSP_OK, "?STATUS,S", SHORT + 40);
    cmd("K,?", RSP_OK, "?K,1.0", SHORT + 40);
  endtask : t_set
  task automatic t_regs;
    logic [31:0] q;
    av(1'b1, REG_CTRL, 32'h64, q);
    av(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h64);
    av(1'b1, REG_STATUS, 32'h0, q);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[12:0], 13'h01ff);
    av(1'b0, 5'h08, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_regs
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    cyc(4);
    t_idle();
    t_short();
    t_bad();
    t_read();
    t_cal();
    t_set();
    t_regs();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
